// ---- sim/xfer_exec_bench.sv ----
`timescale 1ns/1ps
module xfer_exec_bench;
	import xfer_pkg::*;
	typedef struct {op_t o; logic [4:0] d, s; logic [2:0] b; logic [15:0] a; ptr_t p;
		ptr_mode_t m; int c; logic [7:0] v; logic [2:0] l;} row_t;
	logic core_clk = 0, sys_rst = 1, op_valid = 0, debug_en = 0;
	op_t op_code = op_nop;
	ptr_t op_ptr = ptr_x;
	ptr_mode_t op_mode = mode_plain;
	logic [4:0] op_dst = 0, op_src = 0, peek_idx = 0;
	logic [2:0] op_bit = 0, pl;
	logic [15:0] op_addr = 0, dmem_addr, pmem_rdata, pmem_wdata, stack_ptr, pw_d;
	logic [14:0] pmem_addr, pw_a;
	logic [7:0] dmem_wdata, dmem_rdata, port_rdata, status_flag_register, peek_data, e;
	logic [5:0] port_rd_addr;
	logic op_ready, op_done, dmem_we, dmem_re, pmem_re, pmem_we, port_re;
	logic sleep_req, wdt_restart, break_req, global_irq_en;
	int error_cnt = 0, n_compared = 0, n;
	row_t rows[$], w;
	always #5 core_clk = ~core_clk;
	xfer_exec dut (.core_clk, .sys_rst, .op_valid, .op_ready, .op_code, .op_dst, .op_src,
		.op_bit, .op_imm(op_addr[7:0]), .op_addr, .op_disp(op_addr[5:0]), .op_ptr, .op_mode,
		.op_done, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .pmem_addr,
		.pmem_re, .pmem_rdata, .pmem_we, .pmem_wdata, .port_rd_addr, .port_re, .port_rdata,
		.port_wr_addr(), .port_wdata(), .port_we(), .debug_en, .sleep_req, .wdt_restart,
		.break_req, .status_flag_register, .global_irq_en, .stack_ptr, .peek_idx, .peek_data);
	xfer_mem_model mem (.core_clk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata,
		.pmem_addr, .pmem_re, .pmem_rdata, .port_rd_addr, .port_re, .port_rdata);
	always @(negedge core_clk) begin
		if (pmem_we) begin
			pw_a <= pmem_addr;
			pw_d <= pmem_wdata;
		end
	end
	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task chk(input string nm, input logic [15:0] ev, input logic [15:0] gv);
		n_compared++;
		if (gv !== ev) begin
			$display("Error %s expected %h got %h", nm, ev, gv);
			error_cnt++;
		end
	endtask
	// Called at a falling edge; returns cycles to completion and the pulses seen then
	task run(input row_t r, output int cyc, output logic [2:0] pls);
		op_code = r.o;
		op_dst = r.d;
		op_src = r.s;
		op_bit = r.b;
		op_addr = r.a;
		op_ptr = r.p;
		op_mode = r.m;
		op_valid = 1;
		@(posedge core_clk);
		@(negedge core_clk);
		op_valid = 0;
		cyc = 1;
		while (op_done !== 1'b1 && cyc < 9) begin
			@(negedge core_clk);
			cyc++;
		end
		pls = {sleep_req, wdt_restart, break_req};
		peek_idx = r.d;
		#1;
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Run is under a hundred cycles; the limit leaves a wide margin
	initial begin
		#20000;
		error_cnt++;
		test_done;
	end
	// --------------------------------------------------------------
	// Sequence: pointers X=0010, Y=0020, Z=0007; memory holds addr^5a
	// --------------------------------------------------------------
	initial begin
		rows = '{
		'{op_immediate_load,26,0,0,16'h10,ptr_x,mode_plain,1,8'h10,0},
		'{op_immediate_load,28,0,0,16'h20,ptr_x,mode_plain,1,8'h20,0},
		'{op_immediate_load,30,0,0,16'h07,ptr_x,mode_plain,1,8'h07,0},
		'{op_indirect_read,5,0,0,0,ptr_x,mode_post_inc,2,8'h4a,0},
		'{op_register_copy,6,26,0,0,ptr_x,mode_plain,1,8'h11,0},
		'{op_indirect_read,7,0,0,0,ptr_x,mode_pre_dec,2,8'h4a,0},
		'{op_offset_indirect_read,9,0,0,3,ptr_y,mode_plain,2,8'h79,0},
		'{op_direct_read,10,0,0,16'h40,ptr_x,mode_plain,2,8'h1a,0},
		'{op_immediate_load,16,0,0,16'hc3,ptr_x,mode_plain,1,8'hc3,0},
		'{op_indirect_write,16,16,0,0,ptr_x,mode_post_inc,2,8'hc3,0},
		'{op_indirect_read,11,0,0,0,ptr_x,mode_pre_dec,2,8'hc3,0},
		'{op_offset_indirect_write,16,16,0,5,ptr_y,mode_plain,2,8'hc3,0},
		'{op_direct_read,12,0,0,16'h25,ptr_x,mode_plain,2,8'hc3,0},
		'{op_register_copy,13,28,0,0,ptr_x,mode_plain,1,8'h20,0},
		'{op_direct_write,9,9,0,16'h50,ptr_x,mode_plain,2,8'h79,0},
		'{op_direct_read,14,0,0,16'h50,ptr_x,mode_plain,2,8'h79,0},
		'{op_indirect_write,16,16,0,0,ptr_z,mode_pre_dec,2,8'hc3,0},
		'{op_direct_read,15,0,0,16'h06,ptr_x,mode_plain,2,8'hc3,0},
		'{op_push,16,16,0,0,ptr_x,mode_plain,2,8'hc3,0},
		'{op_pop,17,0,0,0,ptr_x,mode_plain,2,8'hc3,0},
		'{op_program_memory_read,0,0,0,0,ptr_z,mode_plain,3,8'hc0,0},
		'{op_program_memory_read,18,0,0,0,ptr_z,mode_post_inc,3,8'hc0,0},
		'{op_program_memory_read,19,0,0,0,ptr_z,mode_post_inc,3,8'h3f,0},
		'{op_register_copy,20,30,0,0,ptr_x,mode_plain,1,8'h08,0},
		'{op_register_pair_copy,2,26,0,0,ptr_x,mode_plain,1,8'h10,0},
		'{op_port_read,21,0,0,16'h11,ptr_x,mode_plain,1,8'h91,0},
		'{op_port_write,21,21,0,16'h12,ptr_x,mode_plain,1,8'h91,0},
		'{op_bit_to_transfer_flag,16,16,1,0,ptr_x,mode_plain,1,8'hc3,0},
		'{op_transfer_flag_to_bit,3,0,4,0,ptr_x,mode_plain,1,8'h10,0},
		'{op_nibble_swap,16,0,0,0,ptr_x,mode_plain,1,8'h3c,0},
		'{op_sleep,0,0,0,0,ptr_x,mode_plain,1,8'hc0,3'b100},
		'{op_watchdog_restart,0,0,0,0,ptr_x,mode_plain,1,8'hc0,3'b010},
		'{op_break,0,0,0,0,ptr_x,mode_plain,1,8'hc0,3'b000}};
		repeat (4) @(negedge core_clk);
		sys_rst = 0;
		chk("ready", 1, op_ready);
		chk("stack_ptr", 16'h00ff, stack_ptr);
		chk("flags", 8'h00, status_flag_register);
		$display("reset test done");
		foreach (rows[i]) begin
			run(rows[i], n, pl);
			chk("cycles", 16'(rows[i].c), 16'(n));
			chk("reg", rows[i].v, peek_data);
			chk("pulses", rows[i].l, pl);
		end
		$display("row test done");
		e = 8'h40;
		w = rows[0];
		for (int i = 0; i < 16; i++) begin
			w.o = i < 8 ? op_flag_set_indexed : op_flag_clear_indexed;
			w.b = i[2:0];
			e = i < 8 ? e | (8'h01 << i[2:0]) : e & ~(8'h01 << i[2:0]);
			run(w, n, pl);
			chk("flags", e, status_flag_register);
			chk("irq_en", e[7], global_irq_en);
		end
		$display("flag test done");
		debug_en = 1;
		w.o = op_break;
		run(w, n, pl);
		chk("break", 3'b001, pl);
		debug_en = 0;
		w.o = op_immediate_load;
		w.d = 1;
		w.a = 16'h005e;
		run(w, n, pl);
		w.o = op_program_memory_write;
		run(w, n, pl);
		chk("pm_addr", 15'h0004, pw_a);
		chk("pm_data", 16'h5ec0, pw_d);
		sys_rst = 1;
		@(negedge core_clk);
		sys_rst = 0;
		chk("reg", 8'h00, peek_data);
		$display("edge case test done");
		test_done;
	end
endmodule // xfer_exec_bench

// ---- sim/xfer_exec_chk.sv ----
`timescale 1ns/1ps
module xfer_exec_chk
	import xfer_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        op_valid,
	input  wire logic        op_ready,
	input  wire op_t         op_code,
	input  wire logic [2:0]  op_bit,
	input  wire logic [15:0] op_addr,
	input  wire logic        debug_en,
	input  wire logic        op_done,
	input  wire logic [15:0] dmem_addr,
	input  wire logic        dmem_re,
	input  wire logic        dmem_we,
	input  wire logic        pmem_re,
	input  wire logic        sleep_req,
	input  wire logic        wdt_restart,
	input  wire logic        break_req,
	input  wire logic [7:0]  status_flag_register
);
	logic acc;
	assign acc = op_valid && op_ready;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_set;
		acc && op_code == op_flag_set_indexed |=> op_done && status_flag_register ==
			($past(status_flag_register) | (8'h01 << $past(op_bit)));
	endproperty
	a_set: assert property (p_set) else $error("flag set wrong");
	property p_clr;
		acc && op_code == op_flag_clear_indexed |=> op_done && status_flag_register ==
			($past(status_flag_register) & ~(8'h01 << $past(op_bit)));
	endproperty
	a_clr: assert property (p_clr) else $error("flag clear wrong");
	property p_tf;
		acc && op_code inside {op_bit_to_transfer_flag, op_transfer_flag_to_bit} |=>
			op_done && (status_flag_register & 8'hbf) == ($past(status_flag_register) & 8'hbf);
	endproperty
	a_tf: assert property (p_tf) else $error("bit op touched flags");
	property p_ld;
		acc && op_code inside {op_indirect_read, op_offset_indirect_read, op_direct_read, op_pop}
			|=> dmem_re && !op_done && $stable(status_flag_register) ##1 op_done && !dmem_re;
	endproperty
	a_ld: assert property (p_ld) else $error("load timing");
	property p_st;
		acc && op_code inside {op_indirect_write, op_offset_indirect_write, op_direct_write,
			op_push} |=> dmem_we && !dmem_re && !op_done ##1 op_done && !dmem_we;
	endproperty
	a_st: assert property (p_st) else $error("store timing");
	property p_dir;
		acc && op_code inside {op_direct_read, op_direct_write} |=> dmem_addr == $past(op_addr);
	endproperty
	a_dir: assert property (p_dir) else $error("direct address");
	property p_pm;
		acc && op_code == op_program_memory_read |=> pmem_re && !op_done ##1 !op_done ##1 op_done;
	endproperty
	a_pm: assert property (p_pm) else $error("program read timing");
	property p_one;
		acc && op_code inside {op_register_copy, op_register_pair_copy, op_immediate_load,
			op_port_read, op_port_write} |=> op_done && op_ready && $stable(status_flag_register);
	endproperty
	a_one: assert property (p_one) else $error("single cycle op");
	property p_slp;
		acc && op_code == op_sleep |=> op_done && sleep_req && !wdt_restart;
	endproperty
	a_slp: assert property (p_slp) else $error("sleep pulse");
	property p_wdr;
		acc && op_code == op_watchdog_restart |=> op_done && wdt_restart && !sleep_req;
	endproperty
	a_wdr: assert property (p_wdr) else $error("watchdog pulse");
	property p_brk;
		acc && op_code == op_break && !debug_en |=> op_done && !break_req;
	endproperty
	a_brk: assert property (p_brk) else $error("break without debug");
endmodule // xfer_exec_chk

bind xfer_exec xfer_exec_chk chk_i (.core_clk, .sys_rst, .op_valid, .op_ready, .op_code,
	.op_bit, .op_addr, .debug_en, .op_done, .dmem_addr, .dmem_re, .dmem_we, .pmem_re,
	.sleep_req, .wdt_restart, .break_req, .status_flag_register);

// ---- sim/xfer_mem_model.sv ----
`timescale 1ns/1ps
module xfer_mem_model
	import xfer_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic [15:0] dmem_addr,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we,
	input  wire logic        dmem_re,
	output logic      [7:0]  dmem_rdata,
	input  wire logic [14:0] pmem_addr,
	input  wire logic        pmem_re,
	output logic      [15:0] pmem_rdata,
	input  wire logic [5:0]  port_rd_addr,
	input  wire logic        port_re,
	output logic      [7:0]  port_rdata
);
	logic [7:0] mem [256];
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	// Garbage outside a strobe so a sample in the wrong cycle shows up
	assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];
	assign port_rdata = port_re ? {2'b10, port_rd_addr} : {2'b01, ~port_rd_addr};
	always @(posedge core_clk) begin
		if (dmem_we)
			mem[dmem_addr[7:0]] <= dmem_wdata;
	end
	// Synchronous store: the word is valid only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (pmem_re)
			pmem_rdata <= {pmem_addr[7:0] ^ 8'h3c, pmem_addr[7:0] ^ 8'hc3};
		else
			pmem_rdata <= ~pmem_rdata;
	end
endmodule // xfer_mem_model

// ---- src/status_flags.sv ----
`timescale 1ns/1ps
module status_flags
	import xfer_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       set_en,
	input  wire logic       clr_en,
	input  wire logic [2:0] flag_idx,
	input  wire logic       t_we,
	input  wire logic       t_val,
	output logic      [7:0] status_flag_register
);

	logic [7:0] flags_ff;

	// Only the addressed flag moves; every other bit holds
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags_ff <= FLAGS_RESET;
		end else if (set_en) begin
			flags_ff[flag_idx] <= 1'b1;
		end else if (clr_en) begin
			flags_ff[flag_idx] <= 1'b0;
		end else if (t_we) begin
			flags_ff[FLAG_T] <= t_val;
		end
	end

	assign status_flag_register = flags_ff;

endmodule // status_flags

// ---- src/work_regs.sv ----
`timescale 1ns/1ps
module work_regs
	import xfer_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_idx,
	input  wire logic [7:0]  wr_data,
	input  wire logic        pw_en,
	input  wire logic [3:0]  pw_pair,
	input  wire logic [15:0] pw_data,
	input  wire logic [4:0]  rd_a_idx,
	output logic      [7:0]  rd_a,
	input  wire logic [4:0]  rd_b_idx,
	output logic      [7:0]  rd_b,
	input  wire logic [4:0]  rd_c_idx,
	output logic      [7:0]  rd_c,
	input  wire logic [3:0]  rd_pair,
	output logic      [15:0] rd_pair_data,
	output logic      [15:0] ptr_x_val,
	output logic      [15:0] ptr_y_val,
	output logic      [15:0] ptr_z_val
);

	logic [7:0] regs_ff [NREG];

	// Byte port wins over the word port when both hit one register
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					regs_ff[gi] <= REG_RESET;
				end else if (wr_en && wr_idx == 5'(gi)) begin
					regs_ff[gi] <= wr_data;
				end else if (pw_en && pw_pair == 4'(gi / 2)) begin
					regs_ff[gi] <= (gi % 2 == 1) ? pw_data[15:8] : pw_data[7:0];
				end
			end
		end
	endgenerate

	assign rd_a         = regs_ff[rd_a_idx];
	assign rd_b         = regs_ff[rd_b_idx];
	assign rd_c         = regs_ff[rd_c_idx];
	assign rd_pair_data = {regs_ff[{rd_pair, 1'b1}], regs_ff[{rd_pair, 1'b0}]};
	assign ptr_x_val    = {regs_ff[{PAIR_X, 1'b1}], regs_ff[{PAIR_X, 1'b0}]};
	assign ptr_y_val    = {regs_ff[{PAIR_Y, 1'b1}], regs_ff[{PAIR_Y, 1'b0}]};
	assign ptr_z_val    = {regs_ff[{PAIR_Z, 1'b1}], regs_ff[{PAIR_Z, 1'b0}]};

endmodule // work_regs

// ---- src/xfer_exec.sv ----
`timescale 1ns/1ps
module xfer_exec
	import xfer_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            sys_rst,
	input  wire logic            op_valid,
	output logic                 op_ready,
	input  wire op_t             op_code,
	input  wire logic [4:0]      op_dst,
	input  wire logic [4:0]      op_src,
	input  wire logic [2:0]      op_bit,
	input  wire logic [7:0]      op_imm,
	input  wire logic [15:0]     op_addr,
	input  wire logic [5:0]      op_disp,
	input  wire ptr_t            op_ptr,
	input  wire ptr_mode_t       op_mode,
	output logic                 op_done,
	output logic [15:0]          dmem_addr,
	output logic [7:0]           dmem_wdata,
	output logic                 dmem_we,
	output logic                 dmem_re,
	input  wire logic [7:0]      dmem_rdata,
	output logic [14:0]          pmem_addr,
	output logic                 pmem_re,
	input  wire logic [15:0]     pmem_rdata,
	output logic                 pmem_we,
	output logic [15:0]          pmem_wdata,
	output logic [5:0]           port_rd_addr,
	output logic                 port_re,
	input  wire logic [7:0]      port_rdata,
	output logic [5:0]           port_wr_addr,
	output logic [7:0]           port_wdata,
	output logic                 port_we,
	input  wire logic            debug_en,
	output logic                 sleep_req,
	output logic                 wdt_restart,
	output logic                 break_req,
	output logic [7:0]           status_flag_register,
	output logic                 global_irq_en,
	output logic [15:0]          stack_ptr,
	input  wire logic [4:0]      peek_idx,
	output logic [7:0]           peek_data
);

	// --------------------------------------------------------------
	// State and held context
	// --------------------------------------------------------------
	state_t      state_ff;
	logic        accept;
	logic        load_ff;
	logic [4:0]  dst_ff;
	logic        post_inc_ff;
	logic [3:0]  post_pair_ff;
	logic [15:0] post_val_ff;
	logic        byte_sel_ff;
	logic [15:0] sp_ff;
	logic        done_ff;
	logic [15:0] dmem_addr_ff;
	logic [7:0]  dmem_wdata_ff;
	logic        dmem_we_ff;
	logic        dmem_re_ff;
	logic [14:0] pmem_addr_ff;
	logic        pmem_re_ff;
	logic        pmem_we_ff;
	logic [15:0] pmem_wdata_ff;
	logic [5:0]  port_wr_addr_ff;
	logic [7:0]  port_wdata_ff;
	logic        port_we_ff;
	logic        sleep_ff;
	logic        wdt_ff;
	logic        break_ff;

	logic        wr_en;
	logic [4:0]  wr_idx;
	logic [7:0]  wr_data;
	logic        pw_en;
	logic [3:0]  pw_pair;
	logic [15:0] pw_data;
	logic [7:0]  src_val;
	logic [7:0]  dst_val;
	logic [15:0] src_pair_val;
	logic [15:0] ptr_x_val;
	logic [15:0] ptr_y_val;
	logic [15:0] ptr_z_val;
	logic [15:0] ptr_val;
	logic [3:0]  ptr_pair;
	logic        is_ind;
	logic        is_mem_rd;
	logic        is_mem_wr;
	logic [15:0] eff_addr;
	logic [7:0]  t_merged;
	logic        fs_en;
	logic        fc_en;
	logic        t_we;

	// Only one operation is in flight; the next waits for idle
	assign op_ready = (state_ff == st_idle);
	assign accept   = op_valid && op_ready;

	// --------------------------------------------------------------
	// Operand selection
	// --------------------------------------------------------------
	always_comb begin
		unique case (op_ptr)
			ptr_x: begin
				ptr_val  = ptr_x_val;
				ptr_pair = PAIR_X;
			end
			ptr_y: begin
				ptr_val  = ptr_y_val;
				ptr_pair = PAIR_Y;
			end
			default: begin
				ptr_val  = ptr_z_val;
				ptr_pair = PAIR_Z;
			end
		endcase
	end

	assign is_ind    = (op_code == op_indirect_read) || (op_code == op_indirect_write);
	assign is_mem_rd = (op_code == op_indirect_read) || (op_code == op_offset_indirect_read)
		|| (op_code == op_direct_read) || (op_code == op_pop);
	assign is_mem_wr = (op_code == op_indirect_write) || (op_code == op_offset_indirect_write)
		|| (op_code == op_direct_write) || (op_code == op_push);

	always_comb begin
		eff_addr = ptr_val;
		unique case (op_code)
			op_indirect_read, op_indirect_write: begin
				if (op_mode == mode_pre_dec) begin
					eff_addr = ptr_val - PTR_STEP;
				end else begin
					eff_addr = ptr_val;
				end
			end
			op_offset_indirect_read, op_offset_indirect_write: begin
				eff_addr = ptr_val + {DISP_PAD, op_disp};
			end
			op_direct_read, op_direct_write: begin
				eff_addr = op_addr;
			end
			op_push: begin
				eff_addr = sp_ff;
			end
			op_pop: begin
				eff_addr = sp_ff + PTR_STEP;
			end
			default: begin
				eff_addr = ptr_val;
			end
		endcase
	end

	// --------------------------------------------------------------
	// Register file write ports
	// --------------------------------------------------------------
	always_comb begin
		t_merged         = dst_val;
		t_merged[op_bit] = status_flag_register[FLAG_T];
	end

	always_comb begin
		wr_en   = 1'b0;
		wr_idx  = op_dst;
		wr_data = src_val;
		if (accept) begin
			unique case (op_code)
				op_register_copy: begin
					wr_en = 1'b1;
				end
				op_immediate_load: begin
					wr_en   = 1'b1;
					wr_data = op_imm;
				end
				op_transfer_flag_to_bit: begin
					wr_en   = 1'b1;
					wr_data = t_merged;
				end
				op_nibble_swap: begin
					wr_en   = 1'b1;
					wr_data = {dst_val[3:0], dst_val[7:4]};
				end
				op_port_read: begin
					wr_en   = 1'b1;
					wr_data = port_rdata;
				end
				default: begin
					wr_en = 1'b0;
				end
			endcase
		end else if (state_ff == st_mem && load_ff) begin
			wr_en   = 1'b1;
			wr_idx  = dst_ff;
			wr_data = dmem_rdata;
		end else if (state_ff == st_pm_data) begin
			wr_en   = 1'b1;
			wr_idx  = dst_ff;
			wr_data = byte_sel_ff ? pmem_rdata[15:8] : pmem_rdata[7:0];
		end
	end

	// Pre-decrement lands at issue, post-increment after the access
	always_comb begin
		pw_en   = 1'b0;
		pw_pair = op_dst[4:1];
		pw_data = src_pair_val;
		if (accept) begin
			if (op_code == op_register_pair_copy) begin
				pw_en = 1'b1;
			end else if (is_ind && op_mode == mode_pre_dec) begin
				pw_en   = 1'b1;
				pw_pair = ptr_pair;
				pw_data = eff_addr;
			end
		end else if ((state_ff == st_mem || state_ff == st_pm_data) && post_inc_ff) begin
			pw_en   = 1'b1;
			pw_pair = post_pair_ff;
			pw_data = post_val_ff;
		end
	end

	assign fs_en = accept && (op_code == op_flag_set_indexed);
	assign fc_en = accept && (op_code == op_flag_clear_indexed);
	assign t_we  = accept && (op_code == op_bit_to_transfer_flag);

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= st_idle;
		end else begin
			unique case (state_ff)
				st_idle: begin
					if (accept && (is_mem_rd || is_mem_wr)) begin
						state_ff <= st_mem;
					end else if (accept && op_code == op_program_memory_read) begin
						state_ff <= st_pm_addr;
					end
				end
				st_mem: begin
					state_ff <= st_idle;
				end
				st_pm_addr: begin
					state_ff <= st_pm_data;
				end
				st_pm_data: begin
					state_ff <= st_idle;
				end
			endcase
		end
	end

	// Context held across the extra cycles of a multi-cycle op
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			load_ff      <= 1'b0;
			dst_ff       <= REG_R0;
			post_inc_ff  <= 1'b0;
			post_pair_ff <= PAIR_Z;
			post_val_ff  <= SP_RESET;
			byte_sel_ff  <= 1'b0;
		end else if (accept) begin
			load_ff      <= is_mem_rd || (op_code == op_program_memory_read);
			dst_ff       <= op_dst;
			post_inc_ff  <= (is_ind || op_code == op_program_memory_read)
				&& (op_mode == mode_post_inc);
			post_pair_ff <= (op_code == op_program_memory_read) ? PAIR_Z : ptr_pair;
			post_val_ff  <= ((op_code == op_program_memory_read) ? ptr_z_val : ptr_val)
				+ PTR_STEP;
			byte_sel_ff  <= ptr_z_val[0];
		end
	end

	// Stack grows downward: push writes then moves, pop moves then reads
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sp_ff <= SP_RESET;
		end else if (accept && op_code == op_push) begin
			sp_ff <= sp_ff - PTR_STEP;
		end else if (accept && op_code == op_pop) begin
			sp_ff <= sp_ff + PTR_STEP;
		end
	end

	// --------------------------------------------------------------
	// Data memory strobes
	// --------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dmem_addr_ff  <= SP_RESET;
			dmem_wdata_ff <= REG_RESET;
			dmem_we_ff    <= 1'b0;
			dmem_re_ff    <= 1'b0;
		end else begin
			dmem_we_ff <= accept && is_mem_wr;
			dmem_re_ff <= accept && is_mem_rd;
			if (accept) begin
				dmem_addr_ff  <= eff_addr;
				dmem_wdata_ff <= src_val;
			end
		end
	end

	// --------------------------------------------------------------
	// Program memory access
	// --------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pmem_addr_ff  <= '0;
			pmem_re_ff    <= 1'b0;
			pmem_we_ff    <= 1'b0;
			pmem_wdata_ff <= '0;
		end else begin
			pmem_re_ff <= accept && (op_code == op_program_memory_read);
			pmem_we_ff <= accept && (op_code == op_program_memory_write);
			if (accept) begin
				pmem_addr_ff  <= ptr_z_val[15:1];
				pmem_wdata_ff <= src_pair_val;
			end
		end
	end

	// --------------------------------------------------------------
	// Port space, control pulses, completion
	// --------------------------------------------------------------
	// Port reads complete in the issue cycle, so the read address is not registered
	assign port_rd_addr = op_addr[5:0];
	assign port_re      = accept && (op_code == op_port_read);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			port_wr_addr_ff <= '0;
			port_wdata_ff   <= REG_RESET;
			port_we_ff      <= 1'b0;
		end else begin
			port_we_ff <= accept && (op_code == op_port_write);
			if (accept) begin
				port_wr_addr_ff <= op_addr[5:0];
				port_wdata_ff   <= src_val;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sleep_ff <= 1'b0;
			wdt_ff   <= 1'b0;
			break_ff <= 1'b0;
		end else begin
			sleep_ff <= accept && (op_code == op_sleep);
			wdt_ff   <= accept && (op_code == op_watchdog_restart);
			// Without debugging the break code retires as a no-op
			break_ff <= accept && (op_code == op_break) && debug_en;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (accept && !is_mem_rd && !is_mem_wr
				&& op_code != op_program_memory_read)
				|| state_ff == st_mem || state_ff == st_pm_data;
		end
	end

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	work_regs u_regs (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.wr_en        (wr_en),
		.wr_idx       (wr_idx),
		.wr_data      (wr_data),
		.pw_en        (pw_en),
		.pw_pair      (pw_pair),
		.pw_data      (pw_data),
		.rd_a_idx     (op_src),
		.rd_a         (src_val),
		.rd_b_idx     (op_dst),
		.rd_b         (dst_val),
		.rd_c_idx     (peek_idx),
		.rd_c         (peek_data),
		.rd_pair      ((op_code == op_program_memory_write) ? REG_R0[4:1] : op_src[4:1]),
		.rd_pair_data (src_pair_val),
		.ptr_x_val    (ptr_x_val),
		.ptr_y_val    (ptr_y_val),
		.ptr_z_val    (ptr_z_val)
	);

	status_flags u_flags (
		.core_clk             (core_clk),
		.sys_rst              (sys_rst),
		.set_en               (fs_en),
		.clr_en               (fc_en),
		.flag_idx             (op_bit),
		.t_we                 (t_we),
		.t_val                (src_val[op_bit]),
		.status_flag_register (status_flag_register)
	);

	assign op_done       = done_ff;
	assign dmem_addr     = dmem_addr_ff;
	assign dmem_wdata    = dmem_wdata_ff;
	assign dmem_we       = dmem_we_ff;
	assign dmem_re       = dmem_re_ff;
	assign pmem_addr     = pmem_addr_ff;
	assign pmem_re       = pmem_re_ff;
	assign pmem_we       = pmem_we_ff;
	assign pmem_wdata    = pmem_wdata_ff;
	assign port_wr_addr  = port_wr_addr_ff;
	assign port_wdata    = port_wdata_ff;
	assign port_we       = port_we_ff;
	assign sleep_req     = sleep_ff;
	assign wdt_restart   = wdt_ff;
	assign break_req     = break_ff;
	assign global_irq_en = status_flag_register[FLAG_I];
	assign stack_ptr     = sp_ff;

endmodule // xfer_exec

// ---- src/xfer_pkg.sv ----
// How it works
// - Selected register bit copied into transfer flag
// - Transfer flag written into selected register bit
// - Set or clear any one flag by index
// - Post-increment read: read, then pointer plus one
// - Pre-decrement read: pointer minus one, then read
// - Offset read at pointer plus displacement, pointer kept
// - Direct read from instruction address, two cycles
// - Post-increment write: write, then pointer plus one
// - Pre-decrement write: pointer minus one, then write
// - Offset write at pointer plus displacement, pointer kept
// - Direct write to instruction address, two cycles
// - Program byte read via third pointer, three cycles
// - Push register onto stack in two cycles
// - Pop stack byte into register, two cycles
// - Sleep issues in one cycle, signals power logic
// - Watchdog restart in one cycle, signals timer
// - Break acts only while debugging is enabled
package xfer_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int NREG   = 32;

	// --------------------------------------------------------------
	// Status flag positions
	// --------------------------------------------------------------
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// --------------------------------------------------------------
	// Register file layout
	// --------------------------------------------------------------
	localparam logic [4:0]  REG_R0      = 5'h00;
	localparam logic [4:0]  REG_R1      = 5'h01;
	localparam logic [3:0]  PAIR_X      = 4'hd;
	localparam logic [3:0]  PAIR_Y      = 4'he;
	localparam logic [3:0]  PAIR_Z      = 4'hf;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [15:0] PTR_STEP    = 16'h0001;
	localparam logic [15:0] SP_RESET    = 16'h00ff;
	localparam logic [9:0]  DISP_PAD    = 10'h000;

	typedef enum logic [4:0] {
		op_nop,
		op_flag_set_indexed,
		op_flag_clear_indexed,
		op_bit_to_transfer_flag,
		op_transfer_flag_to_bit,
		op_nibble_swap,
		op_register_copy,
		op_register_pair_copy,
		op_immediate_load,
		op_indirect_read,
		op_offset_indirect_read,
		op_direct_read,
		op_indirect_write,
		op_offset_indirect_write,
		op_direct_write,
		op_program_memory_read,
		op_program_memory_write,
		op_port_read,
		op_port_write,
		op_push,
		op_pop,
		op_sleep,
		op_watchdog_restart,
		op_break
	} op_t;

	typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_t;
	typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec} ptr_mode_t;
	typedef enum logic [1:0] {st_idle, st_mem, st_pm_addr, st_pm_data} state_t;

endpackage
